// ---- design/hspsel_defs.svh ----
// hspsel_defs.svh: constants for the hub strap and serial pin select block
// assumes inclusion by bare name; definitions only
`ifndef HSPSEL_DEFS_SVH
`define HSPSEL_DEFS_SVH
`define HSPSEL_MODE_I2C_LEVEL 1'b1
`define HSPSEL_PWR_ON_LEVEL 1'b0
`define HSPSEL_OC_ACTIVE_LEVEL 1'b0
`define HSPSEL_OC_PORTS 4
`define HSPSEL_RST_STRAP 1'b0
`define HSPSEL_RST_SEL 1'b1
`endif

// ---- design/hspsel_pkg.sv ----
// hspsel_pkg.sv: types for the hub strap and serial pin select block
// assumes nothing of its surroundings
package hspsel_pkg;
   typedef enum logic [2:0] {
      HSPSEL_ST_RESET = 3'h1,
      HSPSEL_ST_SAMPLE = 3'h2,
      HSPSEL_ST_RUN = 3'h4
   } hspsel_state_t;
endpackage : hspsel_pkg

// ---- design/hspsel_sync.sv ----
// hspsel_sync.sv: two-flop synchroniser for a bus of pin levels
// assumes the levels come from outside the clk domain
module hspsel_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // first stage read only by second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : hspsel_sync

// ---- design/hspsel_top.sv ----
// hspsel_top.sv: strap sampling and shared serial pin routing for a hub
// assumes one clock domain; pins arrive asynchronous; serial engines outside
`include "hspsel_defs.svh"
module hspsel_top #(
   parameter int OC_PORTS = `HSPSEL_OC_PORTS
) (
   input wire logic clk,
   input wire logic rst,
   // serial mode select pin, two-way
   input wire logic serial_mode_select_in,
   output logic serial_mode_select_out,
   output logic serial_mode_select_oe,
   // power management strap pin, two-way
   input wire logic power_mgmt_strap_n_in,
   output logic power_mgmt_strap_n_out,
   output logic power_mgmt_strap_n_oe,
   // over-current inputs, port 4 on the top bit
   input wire logic [OC_PORTS-1:0] port_overcurrent_n,
   // shared clock pin
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // shared data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // I2C controller engine side
   input wire logic ctl_scl_drive_low,
   input wire logic ctl_sda_drive_low,
   output logic ctl_scl_in,
   output logic ctl_sda_in,
   // SMBus target engine side
   input wire logic tgt_scl_hold_low,
   input wire logic tgt_sda_drive_low,
   output logic tgt_scl_in,
   output logic tgt_sda_in,
   // configuration and status
   input wire logic status_output_enable,
   input wire logic ss_suspended,
   input wire logic ss_connected,
   output logic straps_valid,
   output logic i2c_controller_mode,
   output logic smbus_target_mode,
   output logic power_switch_enable,
   output logic target_addr_bit1,
   output logic [OC_PORTS-1:0] overcurrent_event,
   output logic overcurrent_any
);
   hspsel_pkg::hspsel_state_t state;
   hspsel_pkg::hspsel_state_t next_state;
   logic [OC_PORTS+3:0] sync_out;
   logic mode_pin_s;
   logic pwr_pin_s;
   logic scl_s;
   logic sda_s;
   logic [OC_PORTS-1:0] oc_n_s;
   logic mode_strap;
   logic pwr_strap_n;
   logic [OC_PORTS-1:0] oc_evt;
   logic sample_now;
   logic running;
   logic sync_filled;
   logic status_drive;

   // level to event, active low on every over-current pin
   function automatic logic hspsel_oc_active(input logic level_n);
      hspsel_oc_active = (level_n == `HSPSEL_OC_ACTIVE_LEVEL);
   endfunction : hspsel_oc_active

   // unselected engine sees an idle-high line, so it never decodes a start
   function automatic logic hspsel_route(input logic sel, input logic level);
      hspsel_route = sel ? level : 1'b1;
   endfunction : hspsel_route

   ////////////////////////////////////////////////////////////////////////
   // every pin level crosses two flops before use
   hspsel_sync #(
      .WIDTH(OC_PORTS + 4),
      .INIT({{OC_PORTS{1'b1}}, 4'hF})
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .din({port_overcurrent_n, sda_in, scl_in, power_mgmt_strap_n_in,
            serial_mode_select_in}),
      .dout(sync_out)
   );
   assign mode_pin_s = sync_out[0];
   assign pwr_pin_s = sync_out[1];
   assign scl_s = sync_out[2];
   assign sda_s = sync_out[3];
   assign oc_n_s = sync_out[OC_PORTS+3:4];

   ////////////////////////////////////////////////////////////////////////
   // the synchroniser is preset to ones by reset and needs two edges to carry the
   // pin level, so the sequencer waits one edge before the sample state
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_filled <= 1'b0;
      end else begin
         sync_filled <= 1'b1;
      end
   end

   // sequencer: reset, wait for the synchroniser, sample once, then run
   always_comb begin
      next_state = state;
      case (state)
         hspsel_pkg::HSPSEL_ST_RESET: begin
            if (sync_filled) begin
               next_state = hspsel_pkg::HSPSEL_ST_SAMPLE;
            end
         end
         hspsel_pkg::HSPSEL_ST_SAMPLE: next_state = hspsel_pkg::HSPSEL_ST_RUN;
         hspsel_pkg::HSPSEL_ST_RUN: next_state = hspsel_pkg::HSPSEL_ST_RUN;
         default: next_state = hspsel_pkg::HSPSEL_ST_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= hspsel_pkg::HSPSEL_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign sample_now = (state == hspsel_pkg::HSPSEL_ST_SAMPLE);
   assign running = (state == hspsel_pkg::HSPSEL_ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // strap latches, loaded once per reset
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_strap <= `HSPSEL_RST_SEL;
         pwr_strap_n <= `HSPSEL_RST_SEL;
      end else if (sample_now) begin
         mode_strap <= mode_pin_s;
         pwr_strap_n <= pwr_pin_s;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         straps_valid <= 1'b0;
      end else begin
         straps_valid <= sample_now | straps_valid;
      end
   end

   assign i2c_controller_mode = straps_valid & (mode_strap == `HSPSEL_MODE_I2C_LEVEL);
   assign smbus_target_mode = straps_valid & (mode_strap != `HSPSEL_MODE_I2C_LEVEL);
   // address bit follows the strap level; meaningful only in target mode
   assign target_addr_bit1 = pwr_strap_n;

   ////////////////////////////////////////////////////////////////////////
   // power switch enable and over-current gating
   assign power_switch_enable = straps_valid & (pwr_strap_n == `HSPSEL_PWR_ON_LEVEL);

   // unused inputs float high through pull-ups; a wired input counts only while power_switch_enable is high
   always_comb begin
      for (int i = 0; i < OC_PORTS; i++) begin
         oc_evt[i] = power_switch_enable & hspsel_oc_active(oc_n_s[i]);
      end
   end

   // registered, so events drop one edge after the synchronised pin returns high
   always_ff @(posedge clk) begin
      if (rst) begin
         overcurrent_event <= '0;
         overcurrent_any <= 1'b0;
      end else begin
         overcurrent_event <= oc_evt;
         overcurrent_any <= |oc_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strap pins turn into status outputs only after sampling; holding the
   // drivers off until then keeps the strap levels free of our own drive
   assign status_drive = running & status_output_enable;

   // suspend state on the mode select pin
   always_ff @(posedge clk) begin
      if (rst) begin
         serial_mode_select_out <= 1'b0;
         serial_mode_select_oe <= 1'b0;
      end else begin
         serial_mode_select_oe <= status_drive;
         serial_mode_select_out <= ss_suspended;
      end
   end

   // connection state on the power strap pin, under the same enable
   always_ff @(posedge clk) begin
      if (rst) begin
         power_mgmt_strap_n_out <= 1'b0;
         power_mgmt_strap_n_oe <= 1'b0;
      end else begin
         power_mgmt_strap_n_oe <= status_drive;
         power_mgmt_strap_n_out <= ss_connected;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared pin routing, open drain: out is always low, oe pulls
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = i2c_controller_mode ? ctl_scl_drive_low
                 : (smbus_target_mode & tgt_scl_hold_low);
   assign sda_oe = i2c_controller_mode ? ctl_sda_drive_low
                 : (smbus_target_mode & tgt_sda_drive_low);
   // each engine sees idle-high pins when not selected
   assign ctl_scl_in = hspsel_route(i2c_controller_mode, scl_s);
   assign ctl_sda_in = hspsel_route(i2c_controller_mode, sda_s);
   assign tgt_scl_in = hspsel_route(smbus_target_mode, scl_s);
   assign tgt_sda_in = hspsel_route(smbus_target_mode, sda_s);
endmodule : hspsel_top

// ---- verification/hspsel_top_asserts.sv ----
// port checks for hspsel_top
// assumes binding into each hspsel_top
module hspsel_top_asserts #(
   parameter int OC_PORTS = 4
) (
   input wire logic clk, rst, straps_valid, i2c_controller_mode, smbus_target_mode,
   input wire logic power_switch_enable, target_addr_bit1, overcurrent_any,
   input wire logic [OC_PORTS-1:0] port_overcurrent_n, overcurrent_event,
   input wire logic scl_oe, sda_oe, ctl_scl_drive_low, tgt_scl_hold_low, tgt_sda_drive_low,
   input wire logic status_output_enable, ss_suspended, serial_mode_select_oe,
   input wire logic serial_mode_select_out, power_mgmt_strap_n_oe,
   input wire logic ctl_sda_drive_low, ss_connected, power_mgmt_strap_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // port 4 pin held low long enough to pass the synchroniser
   sequence oc4_low_s;
      (straps_valid && power_switch_enable && !port_overcurrent_n[OC_PORTS-1]) [*4];
   endsequence
   oc_event_a: assert property (oc4_low_s |-> overcurrent_event[OC_PORTS-1]
      && overcurrent_any) else $error("port 4 over-current missed");
   oc_ignore_a: assert property (straps_valid && !power_switch_enable
      |-> overcurrent_event == '0) else $error("over-current seen while ignored");
   mode_one_a: assert property (straps_valid |-> i2c_controller_mode ^ smbus_target_mode)
      else $error("mode not exactly one");
   ctl_scl_a: assert property (i2c_controller_mode |-> scl_oe == ctl_scl_drive_low)
      else $error("clock pin not from controller");
   tgt_pins_a: assert property (smbus_target_mode |-> sda_oe == tgt_sda_drive_low
      && scl_oe == tgt_scl_hold_low) else $error("pins not from target");
   strap_hold_a: assert property (straps_valid && $past(straps_valid)
      |-> $stable(i2c_controller_mode) && $stable(target_addr_bit1)
      && $stable(power_switch_enable)) else $error("strap value moved");
   sts_early_a: assert property (!straps_valid
      |-> !serial_mode_select_oe && !power_mgmt_strap_n_oe) else $error("status early");
   sts_en_a: assert property (straps_valid && $past(straps_valid)
      |-> serial_mode_select_oe == $past(status_output_enable)
      && power_mgmt_strap_n_oe == serial_mode_select_oe) else $error("status enable wrong");
   sts_val_a: assert property (serial_mode_select_oe && $past(serial_mode_select_oe)
      |-> serial_mode_select_out == $past(ss_suspended)) else $error("suspend level wrong");
   ctl_sda_a: assert property (i2c_controller_mode |-> sda_oe == ctl_sda_drive_low)
      else $error("data pin not from controller");
   sts_conn_a: assert property (power_mgmt_strap_n_oe && $past(power_mgmt_strap_n_oe)
      |-> power_mgmt_strap_n_out == $past(ss_connected)) else $error("connection level wrong");
endmodule : hspsel_top_asserts
bind hspsel_top hspsel_top_asserts #(.OC_PORTS(OC_PORTS)) u_chk (.*);

// ---- verification/hspsel_far.sv ----
// eeprom or smbus host beside the shared pins
// assumes pull-ups on both lines
module hspsel_far (
   input wire logic clk,
   input wire logic host_en,
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tick = 1'b0;
   // host clocks only while enabled
   always @(posedge clk) tick <= host_en & ~tick;
   // released lines return high
   assign scl = ~(scl_oe | tick);
   assign sda = ~sda_oe;
endmodule : hspsel_far

// ---- verification/tb_top.sv ----
// bench for hspsel_top
// assumes hspsel_far on the shared pins
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, ms = 1, ps = 0, en = 0, su = 0, cn = 0, he = 0;
   logic cc = 0, cd = 0, tc = 0, td = 0;
   logic [3:0] oc = 4'hF;
   wire scl, sda, mo, mv, po, pv, so, do_, ci, sv, i2c, smb, pse, a1, oa;
   wire [3:0] oe;
   wire csi, tsc, tsd, sol, sdl;
   logic hx;
   int bad_count = 0, comparisons = 0;
   always #5 clk = ~clk;
   hspsel_top #(.OC_PORTS(4)) u_hspsel_top (.clk(clk), .rst(rst),
      .serial_mode_select_in(mo ? mv : ms), .serial_mode_select_out(mv),
      .serial_mode_select_oe(mo), .power_mgmt_strap_n_in(po ? pv : ps),
      .power_mgmt_strap_n_out(pv), .power_mgmt_strap_n_oe(po), .port_overcurrent_n(oc),
      .scl_in(scl), .scl_out(sol), .scl_oe(so), .sda_in(sda), .sda_out(sdl), .sda_oe(do_),
      .ctl_scl_drive_low(cc), .ctl_sda_drive_low(cd), .ctl_scl_in(ci), .ctl_sda_in(csi),
      .tgt_scl_hold_low(tc), .tgt_sda_drive_low(td), .tgt_scl_in(tsc), .tgt_sda_in(tsd),
      .status_output_enable(en), .ss_suspended(su), .ss_connected(cn),
      .straps_valid(sv), .i2c_controller_mode(i2c), .smbus_target_mode(smb),
      .power_switch_enable(pse), .target_addr_bit1(a1), .overcurrent_event(oe),
      .overcurrent_any(oa));
   hspsel_far u_hspsel_far (.clk(clk), .host_en(he), .scl_oe(so), .sda_oe(do_),
      .scl(scl), .sda(sda));
   task automatic test_done();
      if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic g, input logic x);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("CHECK FAILED %0t got %b want %b", $time, g, x);
      end
   endtask : chk
   // strap levels held across release; bounded wait
   task automatic boot(input logic m, input logic p);
      int i;
      rst = 1;
      ms = m;
      ps = p;
      step(8);
      rst = 0;
      for (i = 0; i < 20 && sv !== 1'b1; i++) step(1);
      chk(sv, 1'b1);
      if (sv !== 1'b1) test_done();
   endtask : boot
   initial begin
      step(1);
      boot(1'b1, 1'b0);
      chk(i2c, 1'b1);
      chk(pse, 1'b1);
      chk(a1, 1'b0);
      cc = 1;
      cd = 1;
      step(1);
      chk(so, 1'b1);
      chk(do_, 1'b1);
      cc = 0;
      tc = 1;
      ms = 0;
      ps = 1;
      step(4);
      chk(so, 1'b0);
      chk(csi, 1'b0);
      chk(tsd, 1'b1);
      chk(sol, 1'b0);
      chk(sdl, 1'b0);
      chk(i2c, 1'b1);
      chk(a1, 1'b0);
      chk(pse, 1'b1);
      oc = 4'h7;
      step(4);
      chk(oe[3], 1'b1);
      oc = 4'hF;
      step(4);
      chk(oa, 1'b0);
      oc = 4'hE;
      step(4);
      chk(oa, 1'b1);
      chk(oe[0], 1'b1);
      oc = 4'hF;
      step(4);
      en = 1;
      su = 1;
      cn = 1;
      step(2);
      chk(mo, 1'b1);
      chk(mv, 1'b1);
      chk(pv, 1'b1);
      chk(po, 1'b1);
      su = 0;
      step(2);
      chk(mv, 1'b0);
      en = 0;
      boot(1'b0, 1'b1);
      chk(smb, 1'b1);
      chk(pse, 1'b0);
      chk(a1, 1'b1);
      oc = 4'h0;
      he = 1;
      step(4);
      chk(oa, 1'b0);
      chk(so, 1'b1);
      chk(ci, 1'b1);
      chk(oe == 4'h0, 1'b1);
      chk(tsd, 1'b1);
      tc = 0;
      step(3);
      hx = tsc;
      step(1);
      chk(tsc ^ hx, 1'b1);
      test_done();
   end
endmodule : tb_top
